//--- rtl/field_ramp_pkg.sv
/*
  Constants, register map and carrier types of the field output ramp control.
  Assumes one 25 MHz clock and a 32-bit AXI4-Lite register bus.
*/
package field_ramp_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int MINUTE_S = 60;
	localparam int SAMPLE_US = 1000;
	localparam logic [31:0] MINUTE_CYCLES = 32'(MINUTE_S * CLK_HZ);
	localparam logic [31:0] SAMPLE_CYCLES = 32'(SAMPLE_US * (CLK_HZ / 1_000_000));

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_OUT = 8'h04;
	localparam logic [7:0] OFF_OL_RATE = 8'h08;
	localparam logic [7:0] OFF_OL_DEST = 8'h0c;
	localparam logic [7:0] OFF_OL_STAT = 8'h10;
	localparam logic [7:0] OFF_CL_TGT = 8'h14;
	localparam logic [7:0] OFF_CL_RATE = 8'h18;
	localparam logic [7:0] OFF_CL_SETPT = 8'h1c;
	localparam logic [7:0] OFF_CL_STAT = 8'h20;
	localparam logic [7:0] OFF_PI_P = 8'h24;
	localparam logic [7:0] OFF_PI_I = 8'h28;

	// ----------------------------------------
	// Value ranges (output milli-percent, voltage microvolts)
	// ----------------------------------------
	localparam logic signed [31:0] OUT_MAX = 32'sh0001_86a0;
	localparam logic signed [31:0] OUT_MIN = -32'sh0001_86a0;
	localparam logic signed [31:0] OLR_MAX = 32'sh0001_86a0;
	localparam logic signed [31:0] TGT_MAX = 32'sh004c_4b40;
	localparam logic signed [31:0] TGT_MIN = -32'sh004c_4b40;
	localparam logic signed [31:0] CLR_MAX = 32'sh0098_9680;
	localparam logic signed [31:0] INT_MAX = 32'sh4000_0000;
	localparam logic signed [31:0] INT_MIN = -32'sh4000_0000;
	localparam logic signed [31:0] ZERO = 32'sh0000_0000;
	localparam int PI_FRAC = 16;

	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [1:0] MODE_MANUAL = 2'h0;
	localparam logic [1:0] MODE_OPEN = 2'h1;
	localparam logic [1:0] MODE_CLOSED = 2'h2;
	localparam logic [31:0] VAL_RST = 32'h0000_0000;
	localparam logic [31:0] CLST_IDLE = 32'h0000_0000;
	localparam logic [31:0] CLST_APPR = 32'h0000_0001;
	localparam logic [31:0] CLST_DONE = 32'h0000_0002;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		CL_IDLE,
		CL_APPROACH,
		CL_REACHED
	} cl_state_e;

	typedef struct packed {
		logic signed [31:0] kp;
		logic signed [31:0] ki;
	} pi_coef_s;

endpackage

//--- rtl/rate_stepper.sv
/*
  Rate stepper: turns a rate in units per minute into single unit step pulses.
  Assumes rate stays below Period; a larger rate still yields one step a cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module rate_stepper #(
	parameter logic [31:0] Period = 32'h0000_0001
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [31:0] rate,
	output logic step
);

	logic [31:0] acc_r;
	logic [32:0] accSum;
	logic [32:0] accLess;
	logic accOver;

	// Fractional accumulator; overflow past one minute of cycles is one step
	assign accSum = {1'b0, acc_r} + {1'b0, rate};
	assign accLess = accSum - {1'b0, Period};
	assign accOver = accSum >= {1'b0, Period};

	// Cleared while idle so every ramp starts from a whole step
	always_ff @(posedge ref_clk) begin
		if (reset || !run) begin
			acc_r <= 32'h0000_0000;
			step <= 1'b0;
		end else if (accOver) begin
			acc_r <= accLess[31:0];
			step <= 1'b1;
		end else begin
			acc_r <= accSum[31:0];
			step <= 1'b0;
		end
	end

endmodule

`default_nettype wire

//--- rtl/field_ramp_ctrl.sv
/*
  Field output ramp control: manual output, open-loop ramp, closed-loop ramp
  with PI regulation, all reached over an AXI4-Lite slave.
  Assumes the field input voltage arrives from another domain as a 32-bit
  signed microvolt word, and the command link firmware frames each word.
*/
`timescale 1ns/1ps
`default_nettype none

module field_ramp_ctrl #(
	parameter logic [31:0] MinuteCycles = field_ramp_pkg::MINUTE_CYCLES,
	parameter logic [31:0] SampleCycles = field_ramp_pkg::SAMPLE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [31:0] fieldInput,
	output logic signed [31:0] fieldOutput,
	output logic rampActive
);
	import field_ramp_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic signed [31:0] clampVal(
		input logic signed [31:0] v,
		input logic signed [31:0] lo,
		input logic signed [31:0] hi
	);
		logic signed [31:0] r;
		r = v;
		if (v < lo) begin
			r = lo;
		end else if (v > hi) begin
			r = hi;
		end
		return r;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [31:0] fieldMeta_r;
	logic signed [31:0] fieldIn_r;
	logic awHeld_r;
	logic wHeld_r;
	logic [7:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic [1:0] mode_r;
	logic signed [31:0] olRate_r;
	logic signed [31:0] olDest_r;
	logic signed [31:0] clTarget_r;
	logic signed [31:0] clRate_r;
	logic signed [31:0] clSetpt_r;
	cl_state_e clState_r;
	pi_coef_s coef_r;
	logic signed [31:0] integ_r;
	logic [31:0] sampleCnt_r;
	logic sampleTick_r;

	// ----------------------------------------
	// Field input synchroniser
	// ----------------------------------------
	// Two stages; a multi-bit word may tear, the PI filter tolerates one odd sample
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fieldMeta_r <= VAL_RST;
			fieldIn_r <= ZERO;
		end else begin
			fieldMeta_r <= fieldInput;
			fieldIn_r <= fieldMeta_r;
		end
	end

	// ----------------------------------------
	// Write channel decode
	// ----------------------------------------
	logic doWrite;
	logic fullWord;
	logic wrMode;
	logic wrOut;
	logic wrOlRate;
	logic wrOlDest;
	logic wrClTgt;
	logic wrClRate;
	logic wrPiP;
	logic wrPiI;
	logic wrRoHit;
	logic wrHit;
	logic signed [31:0] wrVal;

	// Partial strobes to a mapped offset are answered OKAY but change nothing
	assign doWrite = awHeld_r && wHeld_r && !bvalid;
	assign fullWord = doWrite && (wStrb_r == 4'hf);
	assign wrVal = signed'(wData_r);
	assign wrMode = fullWord && (awAddr_r == OFF_MODE);
	assign wrOut = fullWord && (awAddr_r == OFF_OUT);
	assign wrOlRate = fullWord && (awAddr_r == OFF_OL_RATE);
	assign wrOlDest = fullWord && (awAddr_r == OFF_OL_DEST);
	assign wrClTgt = fullWord && (awAddr_r == OFF_CL_TGT);
	assign wrClRate = fullWord && (awAddr_r == OFF_CL_RATE);
	assign wrPiP = fullWord && (awAddr_r == OFF_PI_P);
	assign wrPiI = fullWord && (awAddr_r == OFF_PI_I);
	assign wrRoHit = (awAddr_r == OFF_OL_STAT) || (awAddr_r == OFF_CL_SETPT)
		|| (awAddr_r == OFF_CL_STAT);
	assign wrHit = (awAddr_r == OFF_MODE) || (awAddr_r == OFF_OUT)
		|| (awAddr_r == OFF_OL_RATE) || (awAddr_r == OFF_OL_DEST)
		|| (awAddr_r == OFF_CL_TGT) || (awAddr_r == OFF_CL_RATE)
		|| (awAddr_r == OFF_PI_P) || (awAddr_r == OFF_PI_I) || wrRoHit;

	// ----------------------------------------
	// AXI write handshake
	// ----------------------------------------
	// One write in flight: address and data may come in either order
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= VAL_RST;
			wStrb_r <= 4'h0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= {awaddr[7:2], 2'h0};
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wHeld_r <= 1'b1;
				wData_r <= wdata;
				wStrb_r <= wstrb;
				wready <= 1'b0;
			end
			if (doWrite) begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	logic [31:0] clStateCode;
	logic rdHit;
	logic [31:0] rdWord;

	assign clStateCode = (clState_r == CL_APPROACH) ? CLST_APPR
		: (clState_r == CL_REACHED) ? CLST_DONE : CLST_IDLE;

	// Reads have no side effects, so an output read never disturbs a ramp
	assign rdWord = (araddr[7:2] == OFF_MODE[7:2]) ? {30'h0, mode_r}
		: (araddr[7:2] == OFF_OUT[7:2]) ? fieldOutput
		: (araddr[7:2] == OFF_OL_RATE[7:2]) ? olRate_r
		: (araddr[7:2] == OFF_OL_DEST[7:2]) ? olDest_r
		: (araddr[7:2] == OFF_OL_STAT[7:2]) ? {31'h0, rampActive}
		: (araddr[7:2] == OFF_CL_TGT[7:2]) ? clTarget_r
		: (araddr[7:2] == OFF_CL_RATE[7:2]) ? clRate_r
		: (araddr[7:2] == OFF_CL_SETPT[7:2]) ? clSetpt_r
		: (araddr[7:2] == OFF_CL_STAT[7:2]) ? clStateCode
		: (araddr[7:2] == OFF_PI_P[7:2]) ? coef_r.kp
		: (araddr[7:2] == OFF_PI_I[7:2]) ? coef_r.ki
		: VAL_RST;
	assign rdHit = (araddr[7:2] <= OFF_PI_I[7:2]);

	// ----------------------------------------
	// AXI read handshake
	// ----------------------------------------
	// Answer one cycle after the address is taken; unmapped reads give SLVERR
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= VAL_RST;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rdWord;
			rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// Rate steppers and PI sample tick
	// ----------------------------------------
	logic olStep;
	logic clStep;
	logic clRun;

	assign clRun = (clState_r == CL_APPROACH);

	rate_stepper #(
		.Period(MinuteCycles)
	) olStepper (
		.ref_clk(ref_clk),
		.reset(reset),
		.run(rampActive),
		.rate(olRate_r),
		.step(olStep)
	);

	rate_stepper #(
		.Period(MinuteCycles)
	) clStepper (
		.ref_clk(ref_clk),
		.reset(reset),
		.run(clRun),
		.rate(clRate_r),
		.step(clStep)
	);

	// Regulator updates once per sample period, not every clock
	always_ff @(posedge ref_clk) begin
		if (reset || sampleCnt_r == SampleCycles - 32'h1) begin
			sampleCnt_r <= 32'h0;
			sampleTick_r <= !reset;
		end else begin
			sampleCnt_r <= sampleCnt_r + 32'h1;
			sampleTick_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// PI regulator datapath
	// ----------------------------------------
	logic loopOn;
	logic signed [31:0] loopErr;
	logic signed [31:0] integSum;
	logic signed [63:0] piSum;
	logic signed [63:0] piScaled;
	logic signed [31:0] piOut;

	assign loopOn = (mode_r == MODE_CLOSED) && (clState_r != CL_IDLE);
	assign loopErr = clSetpt_r - fieldIn_r;
	assign integSum = clampVal(integ_r + loopErr, INT_MIN, INT_MAX);
	// Integral held bounded so the product never wraps
	assign piSum = coef_r.kp * loopErr + coef_r.ki * integ_r;
	assign piScaled = piSum >>> PI_FRAC;
	assign piOut = (piScaled > 64'(OUT_MAX)) ? OUT_MAX
		: (piScaled < 64'(OUT_MIN)) ? OUT_MIN : piScaled[31:0];

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Written rates are clamped to their ranges; mode and PI gains are stored as written
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mode_r <= MODE_RST;
			olRate_r <= ZERO;
			clRate_r <= ZERO;
			coef_r <= '0;
		end else begin
			if (wrMode) begin
				mode_r <= wData_r[1:0];
			end
			if (wrOlRate) begin
				olRate_r <= clampVal(wrVal, ZERO, OLR_MAX);
			end
			if (wrClRate) begin
				clRate_r <= clampVal(wrVal, ZERO, CLR_MAX);
			end
			if (wrPiP) begin
				coef_r.kp <= wrVal;
			end
			if (wrPiI) begin
				coef_r.ki <= wrVal;
			end
		end
	end

	// ----------------------------------------
	// Open-loop ramp and field output
	// ----------------------------------------
	logic olStart;
	logic olArrive;
	logic signed [31:0] olToward;

	assign olStart = wrOlDest && (olRate_r != ZERO)
		&& ((mode_r == MODE_OPEN) || (mode_r == MODE_CLOSED));
	assign olArrive = (fieldOutput == olDest_r);
	assign olToward = (olDest_r > fieldOutput) ? fieldOutput + 32'sh1
		: fieldOutput - 32'sh1;

	// A manual write wins over ramp steps and the regulator
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fieldOutput <= ZERO;
			olDest_r <= ZERO;
			rampActive <= 1'b0;
		end else begin
			if (wrOlDest) begin
				olDest_r <= clampVal(wrVal, OUT_MIN, OUT_MAX);
			end
			if (wrOut) begin
				fieldOutput <= clampVal(wrVal, OUT_MIN, OUT_MAX);
				rampActive <= 1'b0;
			end else if (olStart) begin
				rampActive <= 1'b1;
			end else if (rampActive && olArrive) begin
				rampActive <= 1'b0;
			end else if (rampActive && olStep) begin
				fieldOutput <= olToward;
			end else if (!rampActive && loopOn && sampleTick_r) begin
				fieldOutput <= piOut;
			end
		end
	end

	// ----------------------------------------
	// Closed-loop target, setpoint and state
	// ----------------------------------------
	logic clStart;
	logic clArrive;
	logic signed [31:0] clToward;

	assign clStart = wrClTgt && (clRate_r != ZERO) && (mode_r == MODE_CLOSED);
	assign clArrive = (clSetpt_r == clTarget_r);
	assign clToward = (clTarget_r > clSetpt_r) ? clSetpt_r + 32'sh1
		: clSetpt_r - 32'sh1;

	// Leaving mode two or a manual write drops the loop and its integral
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			clTarget_r <= ZERO;
			clSetpt_r <= ZERO;
			clState_r <= CL_IDLE;
			integ_r <= ZERO;
		end else begin
			if (wrClTgt) begin
				clTarget_r <= clampVal(wrVal, TGT_MIN, TGT_MAX);
			end
			if (wrOut || (wrMode && wData_r[1:0] != MODE_CLOSED)) begin
				clState_r <= CL_IDLE;
				integ_r <= ZERO;
			end else begin
				case (clState_r)
					CL_IDLE: begin
						if (clStart) begin
							clState_r <= CL_APPROACH;
						end
					end
					CL_APPROACH: begin
						if (clArrive) begin
							clState_r <= CL_REACHED;
						end else if (clStep) begin
							clSetpt_r <= clToward;
						end
					end
					default: begin
						if (clStart) begin
							clState_r <= CL_APPROACH;
						end
					end
				endcase
				if (loopOn && sampleTick_r) begin
					integ_r <= integSum;
				end
			end
		end
	end

endmodule

`default_nettype wire

//--- tb/field_ramp_chk.sv
/*
  Port checker for the field output ramp control.
  Assumes it is bound to field_ramp_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module field_ramp_chk (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic signed [31:0] fieldOutput,
	input wire logic rampActive
);
	import field_ramp_pkg::*;

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// Output never leaves full scale, whatever drives it
	a_out_range: assert property (fieldOutput >= OUT_MIN && fieldOutput <= OUT_MAX)
		else $error("field output out of range");
	a_reset_defaults: assert property ($fell(reset) |-> !bvalid && !rvalid && !rampActive && fieldOutput == ZERO)
		else $error("outputs not at defaults after reset");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write response missing");
	a_bvalid_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_wr_ready_low: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while response pending");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read data missing");
	a_rvalid_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_rd_ready_low: assert property (rvalid |-> !arready)
		else $error("read taken while data pending");
	// A running ramp moves the output one unit at a time, never jumps
	a_ramp_step: assert property (rampActive && $past(rampActive) |->
		(fieldOutput - $past(fieldOutput)) inside {32'shffff_ffff, 32'sh0, 32'sh1})
		else $error("ramp step too large");

	cover property (rampActive);
	cover property ($fell(rampActive));
	cover property (bvalid && bready && bresp == RESP_SLVERR);
endmodule

bind field_ramp_ctrl field_ramp_chk u_chk (.ref_clk, .reset, .awvalid, .awready, .wvalid, .wready, .bresp,
	.bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .fieldOutput, .rampActive);

`default_nettype wire

//--- tb/field_sense_model.sv
/*
  Field input source standing in for the sensing side.
  Assumes the bench sets the level; the word changes just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module field_sense_model (
	input wire logic ref_clk,
	input wire logic [31:0] level,
	output logic [31:0] fieldInput
);
	// One whole binary word per reading, never a partial update
	always_ff @(posedge ref_clk) begin
		fieldInput <= level;
	end
endmodule

`default_nettype wire

//--- tb/tb_field_output_ramp_control.sv
/*
  Self-checking bench for the field output ramp control over AXI4-Lite.
  Assumes shortened minute and sample counts so ramps finish quickly.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_field_output_ramp_control;
	import field_ramp_pkg::*;

	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] level = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, rampActive;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, fieldInput, v;
	logic signed [31:0] fieldOutput;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;

	// Short minute keeps a 50-unit ramp near 500 cycles
	field_ramp_ctrl #(.MinuteCycles(32'h0000_1770), .SampleCycles(32'h0000_0010)) u_dut (.ref_clk(ref_clk),
		.reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.fieldInput(fieldInput), .fieldOutput(fieldOutput), .rampActive(rampActive));
	field_sense_model u_sense (.ref_clk(ref_clk), .level(level), .fieldInput(fieldInput));

	initial begin
		forever #20 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	// Bready and rready rise with the request, so the answer edge is the handshake edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", 32'(bresp), 32'(er));
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] er = RESP_OKAY);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		v = rdata;
		chk("rresp", 32'(rresp), 32'(er));
	endtask

	task automatic wrap_up;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Hang guard, far above the roughly 2000 cycles the tests need
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up;
		end
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		for (int a = 0; a <= 40; a += 4) begin
			rd(8'(a));
			chk("default", v, VAL_RST);
		end
		rd(8'h2c, RESP_SLVERR);
		wr(8'h30, 32'h1, RESP_SLVERR);
		// Zero rate: destination is stored but nothing moves
		wr(OFF_MODE, 32'h1);
		wr(OFF_OL_DEST, 32'h32);
		rd(OFF_OL_STAT);
		chk("norate", v, 32'h0);
		rd(OFF_OL_DEST);
		chk("dest", v, 32'h32);
		wr(OFF_OL_RATE, 32'h258);
		rd(OFF_OL_RATE);
		chk("rate", v, 32'h258);
		// Ramp in each mode; manual mode must not start one
		for (int m = 0; m < 3; m++) begin
			wr(OFF_MODE, 32'(m));
			wr(OFF_OUT, 32'h0);
			wr(OFF_OL_DEST, 32'h32);
			rd(OFF_OL_STAT);
			chk("status", v, 32'(m != 0));
			repeat (100) @(posedge ref_clk);
			rd(OFF_OUT);
			chk("midramp", 32'(v > 32'h0 && v < 32'h32), 32'(m != 0));
			rd(OFF_OL_STAT);
			chk("still", v, 32'(m != 0));
			chk("actpin", 32'(rampActive), 32'(m != 0));
			for (int i = 0; i < 1000 && rampActive === 1'b1; i++) @(posedge ref_clk);
			rd(OFF_OUT);
			chk("arrive", v, (m != 0) ? 32'h32 : 32'h0);
			chk("outpin", fieldOutput, (m != 0) ? 32'h32 : 32'h0);
			rd(OFF_OL_STAT);
			chk("idle", v, 32'h0);
		end
		// Manual write in mid-ramp, then clamping at both ends
		wr(OFF_OL_DEST, 32'hffff_ffec);
		repeat (20) @(posedge ref_clk);
		wr(OFF_OUT, 32'h309);
		rd(OFF_OL_STAT);
		chk("ended", v, 32'h0);
		rd(OFF_OUT);
		chk("forced", v, 32'h309);
		wr(OFF_OUT, 32'h0003_0d40);
		rd(OFF_OUT);
		chk("clamphi", v, 32'h0001_86a0);
		wr(OFF_OUT, 32'hfffc_f2c0);
		rd(OFF_OUT);
		chk("clamplo", v, 32'hfffe_7960);
		// Closed loop starts only in mode two with a nonzero rate; unity gain for the loop
		wr(OFF_MODE, 32'h1);
		wr(OFF_PI_P, 32'h0001_0000);
		rd(OFF_PI_P);
		chk("pip", v, 32'h0001_0000);
		wr(OFF_CL_RATE, 32'h3e8);
		wr(OFF_CL_TGT, 32'h1388);
		rd(OFF_CL_STAT);
		chk("clmode", v, CLST_IDLE);
		wr(OFF_MODE, 32'h2);
		wr(OFF_CL_RATE, 32'h0);
		wr(OFF_CL_TGT, 32'h1388);
		rd(OFF_CL_STAT);
		chk("clrate", v, CLST_IDLE);
		wr(OFF_CL_RATE, 32'h3e8);
		wr(OFF_CL_TGT, 32'h1388);
		rd(OFF_CL_STAT);
		chk("clrun", v, CLST_APPR);
		rd(OFF_CL_TGT);
		chk("tgt", v, 32'h1388);
		rd(OFF_CL_SETPT);
		chk("setpt", 32'(v != 32'h1388), 32'h1);
		// Near target: setpoint arrives, loop holds, unity gain with zero input gives the setpoint
		wr(OFF_CL_TGT, 32'h0000_000a);
		repeat (200) @(posedge ref_clk);
		rd(OFF_CL_STAT);
		chk("clreach", v, CLST_DONE);
		rd(OFF_CL_SETPT);
		chk("setptfin", v, 32'h0000_000a);
		rd(OFF_OUT);
		chk("piout", v, 32'h0000_000a);
		wr(OFF_CL_TGT, 32'h005b_8d80);
		rd(OFF_CL_TGT);
		chk("tgtclamp", v, 32'h004c_4b40);
		wr(OFF_MODE, 32'h0);
		wrap_up;
	end
endmodule

`default_nettype wire
